// *** obl_consts.vh ***
`ifndef OBL_CONSTS_VH
`define OBL_CONSTS_VH
// Flash location of the option byte
`define OBL_OPT_ADDR 16'h0080
// Avalon register byte offsets
`define OBL_REG_OPT 4'h0
`define OBL_REG_CFG 4'h4
`define OBL_REG_SLOW 4'h8
`define OBL_REG_STAT 4'hc
// Option byte fields
`define OBL_FIXED_HI 7
`define OBL_WAIT_HI 6
`define OBL_WAIT_LO 5
`define OBL_FIXED_LO 4
`define OBL_RPIN 3
`define OBL_SRC_HI 2
`define OBL_SRC_LO 1
`define OBL_LOCK 0
// Settle wait exponents, in main clock periods
`define OBL_WAIT_EXP0 10
`define OBL_WAIT_EXP1 12
`define OBL_WAIT_EXP2 15
`define OBL_WAIT_EXP3 17
// Flash read latency in cycles
`define OBL_FETCH_CYC 2
`endif

// *** settle_timer.v ***
`include "obl_consts.vh"
module settle_timer #(
  parameter integer CW = 18
) (
  input wire ref_clk,          // Main clock
  input wire arst_n,           // Async reset, active low
  input wire start,            // Load count, one cycle
  input wire [1:0] sel,        // Settle wait select
  input wire skip,             // No wait for this source
  output reg done_r            // Wait elapsed
);
  reg [CW-1:0] cnt_r;
  reg run_r;

  function [CW-1:0] wait_len;
    input [1:0] s;
    begin
      case (s)
        2'b00: wait_len = {{(CW-1){1'b0}}, 1'b1} << `OBL_WAIT_EXP0;
        2'b01: wait_len = {{(CW-1){1'b0}}, 1'b1} << `OBL_WAIT_EXP1;
        2'b10: wait_len = {{(CW-1){1'b0}}, 1'b1} << `OBL_WAIT_EXP2;
        default: wait_len = {{(CW-1){1'b0}}, 1'b1} << `OBL_WAIT_EXP3;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= {CW{1'b0}};
      run_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (start)
    begin
      done_r <= skip; // RQ3
      run_r <= ~skip;
      cnt_r <= wait_len(sel) - {{(CW-1){1'b0}}, 1'b1}; // RQ2
    end
    else if (run_r)
    begin
      if (cnt_r == {CW{1'b0}})
      begin
        run_r <= 1'b0;
        done_r <= 1'b1;
      end
      else
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule

// *** boot_option_byte_loader.v ***
// Summary of operation
// RQ1: Option byte at flash 0080H; bits 7,4 are one; fields as laid out.
// RQ2: Settle field 00/01/10/11 waits 2^10/2^12/2^15/2^17 clock periods.
// RQ3: Settle wait only for crystal source; none for internal or external.
// RQ4: Reset pin control 1 keeps reset input; 0 makes it input port.
// RQ5: Fetch after reset release; pin low before fetch end keeps reset.
// RQ6: Source 00 crystal, 01 external clock, 1x internal high-speed osc.
// RQ7: Crystal uses both osc pins, external first only, internal none.
// RQ8: Lock 1 keeps slow osc running, ignoring halt; 0 lets halt stop it.
// RQ9: Lock 1 forces watchdog count clock from the slow oscillator.
// RQ10: Unlocked: watchdog clock gated in HALT/STOP or non-slow selection.
// RQ11: Slow osc running keeps feeding the aux 8-bit timer, even in STOP.
// RQ12: Programmer must power before target when reset pin is a port.
// RQ13: Option byte read automatically at every start, before operation.
// RQ14: Fields latched once per reset, constant until the next reset.
`include "obl_consts.vh"
module boot_option_byte_loader #(
  parameter integer CW = 18
) (
  input wire ref_clk,              // Main clock, 100 MHz
  input wire arst_n,               // Async reset, active low
  input wire reset_pin,            // Reset pin level, from outside
  output reg [15:0] flash_addr,    // Flash read address
  output reg flash_rd,             // Flash read strobe
  input wire [7:0] flash_rdata,    // Flash read data
  input wire halt_mode,            // CPU in HALT
  input wire stop_mode,            // CPU in STOP
  input wire wdt_sel_slow,         // Watchdog wants slow clock
  input wire [3:0] avs_address,    // Avalon byte address
  input wire avs_read,             // Avalon read
  input wire avs_write,            // Avalon write
  input wire [31:0] avs_writedata, // Avalon write data
  output reg [31:0] avs_readdata,  // Avalon read data
  output reg avs_waitrequest,      // Avalon wait
  output reg sys_rst_n,            // Internal reset, active low
  output reg cpu_run,              // Normal operation may begin
  output reg reset_pin_keep,       // Pin acts as reset
  output reg reset_alt_port_en,    // Pin acts as input port
  output reg [1:0] sysclk_src,     // 00 xtal, 01 ext, 10 internal
  output reg osc_in_pin_en,        // First osc pin used for clock
  output reg osc_out_pin_en,       // Second osc pin used for clock
  output reg osc_in_port_en,       // First osc pin is a port
  output reg osc_out_port_en,      // Second osc pin is a port
  output reg slow_osc_run,         // Slow oscillator enable
  output reg wdt_clk_en,           // Watchdog count clock gate
  output reg wdt_clk_force_slow,   // Watchdog forced to slow clock
  output reg tmr_clk_en            // Aux 8-bit timer clock gate
);
  // ****************************************
  // Sequencer
  // ****************************************
  localparam [2:0] S_HOLD = 3'd0;
  localparam [2:0] S_FETCH = 3'd1;
  localparam [2:0] S_SETTLE = 3'd2;
  localparam [2:0] S_RUN = 3'd3;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg pin_s1_r;
  reg pin_s2_r;
  reg [1:0] fcnt_r;
  reg [7:0] opt_r;
  reg settle_go_r;
  reg slow_halt_r;
  reg pend_r;
  wire settle_done;

  wire [1:0] src = {opt_r[`OBL_SRC_HI], opt_r[`OBL_SRC_LO]};
  wire lock = opt_r[`OBL_LOCK];
  wire fetch_end = (state_r == S_FETCH) && (fcnt_r == 2'd0);
  wire [7:0] fetched = flash_rdata;
  wire [1:0] f_src = {fetched[`OBL_SRC_HI], fetched[`OBL_SRC_LO]};
  wire sleep = halt_mode | stop_mode;

  // Pin is asynchronous to ref_clk
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= reset_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      S_HOLD:
        if (pin_s2_r)
          state_nxt = S_FETCH; // RQ13
      S_FETCH:
        if (!pin_s2_r)
          state_nxt = S_HOLD; // RQ5
        else if (fcnt_r == 2'd0)
          state_nxt = S_SETTLE;
      S_SETTLE:
        if (settle_done && !settle_go_r)
          state_nxt = S_RUN;
      S_RUN:
        // Pin resets only while it is still the reset input
        if (!pin_s2_r && opt_r[`OBL_RPIN])
          state_nxt = S_HOLD; // RQ4
      default:
        state_nxt = S_HOLD;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= S_HOLD;
      fcnt_r <= 2'd0;
      opt_r <= 8'h91;
      settle_go_r <= 1'b0;
      flash_addr <= 16'h0000;
      flash_rd <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      settle_go_r <= fetch_end && pin_s2_r;
      flash_addr <= `OBL_OPT_ADDR; // RQ1
      flash_rd <= (state_nxt == S_FETCH);
      if (state_r == S_HOLD)
        fcnt_r <= `OBL_FETCH_CYC;
      else if (state_r == S_FETCH && fcnt_r != 2'd0)
        fcnt_r <= fcnt_r - 2'd1;
      // Latched once; frozen until the next reset
      if (fetch_end && pin_s2_r)
        opt_r <= fetched; // RQ14
    end
  end

  settle_timer #(
    .CW(CW)
  ) u_settle (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(settle_go_r),
    .sel({opt_r[`OBL_WAIT_HI], opt_r[`OBL_WAIT_LO]}),
    .skip(src != 2'b00), // RQ3
    .done_r(settle_done)
  );

  // ****************************************
  // Configuration outputs
  // ****************************************
  wire running = (state_r == S_RUN);
  wire slow_on = lock | ~slow_halt_r; // RQ8

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sys_rst_n <= 1'b0;
      cpu_run <= 1'b0;
      reset_pin_keep <= 1'b1;
      reset_alt_port_en <= 1'b0;
      sysclk_src <= 2'b10;
      osc_in_pin_en <= 1'b0;
      osc_out_pin_en <= 1'b0;
      osc_in_port_en <= 1'b0;
      osc_out_port_en <= 1'b0;
      slow_osc_run <= 1'b1;
      wdt_clk_en <= 1'b0;
      wdt_clk_force_slow <= 1'b0;
      tmr_clk_en <= 1'b0;
    end
    else
    begin
      sys_rst_n <= running; // RQ5
      cpu_run <= running; // RQ13
      reset_pin_keep <= opt_r[`OBL_RPIN]; // RQ4
      reset_alt_port_en <= running & ~opt_r[`OBL_RPIN]; // RQ4
      sysclk_src <= src[1] ? 2'b10 : src; // RQ6
      osc_in_pin_en <= ~src[1]; // RQ7
      osc_out_pin_en <= (src == 2'b00); // RQ7
      osc_in_port_en <= src[1]; // RQ7
      osc_out_port_en <= (src != 2'b00); // RQ7
      slow_osc_run <= slow_on; // RQ8
      wdt_clk_force_slow <= lock; // RQ9
      if (lock)
        wdt_clk_en <= running; // RQ9
      else
        wdt_clk_en <= running & slow_on & ~sleep & wdt_sel_slow; // RQ10
      tmr_clk_en <= running & slow_on; // RQ11
    end
  end

  // ****************************************
  // Avalon slave
  // ****************************************
  // Fixed one wait state: answer at second edge of each request
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pend_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      slow_halt_r <= 1'b0;
    end
    else
    begin
      pend_r <= (avs_read | avs_write) & ~pend_r;
      avs_waitrequest <= ~((avs_read | avs_write) & ~pend_r);
      if ((avs_read | avs_write) & ~pend_r)
      begin
        avs_readdata <= 32'h0000_0000;
        if (avs_read)
          case (avs_address)
            `OBL_REG_OPT: avs_readdata <= {24'h00_0000, opt_r};
            `OBL_REG_CFG: avs_readdata <= {26'h000_0000, cpu_run,
              reset_pin_keep, sysclk_src, wdt_clk_en, tmr_clk_en};
            `OBL_REG_SLOW: avs_readdata <= {31'h0000_0000, slow_halt_r};
            `OBL_REG_STAT: avs_readdata <= {29'h0000_0000, state_r};
            default: avs_readdata <= 32'h0000_0000;
          endcase
      end
      // Write lands on the answer edge only; lock overrides its effect
      if (avs_write && pend_r && avs_address == `OBL_REG_SLOW)
        slow_halt_r <= avs_writedata[0]; // RQ8
    end
  end
endmodule

// *** boot_option_byte_loader_assertions.sv ***
module boot_option_byte_loader_assertions (
  input logic ref_clk, arst_n, reset_pin, flash_rd, halt_mode, stop_mode,
  input logic wdt_sel_slow, avs_read, avs_write, avs_waitrequest, cpu_run,
  input logic reset_pin_keep, reset_alt_port_en, osc_in_pin_en,
  input logic osc_out_pin_en, osc_in_port_en, osc_out_port_en,
  input logic slow_osc_run, wdt_clk_en, wdt_clk_force_slow, tmr_clk_en,
  input logic [15:0] flash_addr, // Fetch address
  input logic [1:0] sysclk_src   // Clock source
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [3:0] pins = {osc_in_pin_en, osc_out_pin_en, osc_in_port_en,
    osc_out_port_en};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Outputs lag the state by one edge, so wait for two RUN samples
  sequence s_up;
    cpu_run && $past(cpu_run);
  endsequence
  a_fetch_addr: assert property (flash_rd |-> flash_addr == 16'h0080)
    else $error("fetch away from option byte");
  a_src_legal: assert property (s_up |-> sysclk_src != 2'b11)
    else $error("illegal clock source");
  a_xtal_pins: assert property (s_up and sysclk_src == 2'b00 |-> pins == 4'hc)
    else $error("crystal pin sharing wrong");
  a_ext_pins: assert property (s_up and sysclk_src == 2'b01 |-> pins == 4'h9)
    else $error("external clock pin sharing wrong");
  a_int_pins: assert property (s_up and sysclk_src == 2'b10 |-> pins == 4'h3)
    else $error("internal clock pin sharing wrong");
  a_pin_role: assert property (s_up |-> reset_alt_port_en != reset_pin_keep)
    else $error("reset pin role wrong");
  a_lock_force: assert property (s_up and wdt_clk_force_slow |->
    wdt_clk_en && slow_osc_run) else $error("locked slow clock stopped");
  a_wdt_gate: assert property ((!wdt_clk_force_slow && (halt_mode ||
    stop_mode || !wdt_sel_slow)) [*2] |-> !wdt_clk_en)
    else $error("watchdog clock not gated");
  a_tmr_feed: assert property (s_up and slow_osc_run && $past(slow_osc_run)
    |-> tmr_clk_en) else $error("timer clock lost");
  a_hold_reset: assert property (!reset_pin [*6] |-> !flash_rd)
    else $error("fetch while reset pin low");
  a_one_wait: assert property ((avs_read || avs_write) && !avs_waitrequest
    |=> avs_waitrequest) else $error("answer held too long");
endmodule

// *** flash_opt_model.sv ***
module flash_opt_model (
  input logic ref_clk,          // Clock
  input logic flash_rd,         // Read strobe
  input logic [15:0] flash_addr, // Address
  input logic [7:0] opt,        // Stored option byte
  output logic [7:0] flash_rdata // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial flash_rdata = 8'h00;
  // Toggle when not read so a stale byte flips to its inverse every cycle
  always @(posedge ref_clk)
    flash_rdata <= (flash_rd && flash_addr == 16'h0080) ? opt : ~flash_rdata;
endmodule

// *** boot_option_byte_loader_tb_top.sv ***
`include "obl_consts.vh"
module boot_option_byte_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, arst_n = 0, reset_pin = 0, halt_mode = 0, stop_mode = 0;
  logic wdt_sel_slow = 1, avs_read = 0, avs_write = 0, flash_rd, cpu_run;
  logic sys_rst_n, avs_waitrequest, reset_pin_keep, reset_alt_port_en;
  logic osc_in_pin_en, osc_out_pin_en, osc_in_port_en, osc_out_port_en;
  logic slow_osc_run, wdt_clk_en, wdt_clk_force_slow, tmr_clk_en;
  logic [3:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic [7:0] opt = 8'h91, flash_rdata;
  logic [15:0] flash_addr;
  logic [1:0] sysclk_src, src;
  logic [7:0] cases [5] = '{8'h91, 8'hba, 8'hfe, 8'hb5, 8'hb8};
  int err_count = 0, n_tests = 0, t;
  always #5 ref_clk = ~ref_clk;
  boot_option_byte_loader dut_u (.ref_clk, .arst_n, .reset_pin, .flash_addr,
    .flash_rd, .flash_rdata, .halt_mode, .stop_mode, .wdt_sel_slow,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .sys_rst_n, .cpu_run, .reset_pin_keep,
    .reset_alt_port_en, .sysclk_src, .osc_in_pin_en, .osc_out_pin_en,
    .osc_in_port_en, .osc_out_port_en, .slow_osc_run, .wdt_clk_en,
    .wdt_clk_force_slow, .tmr_clk_en);
  flash_opt_model flash_u (.ref_clk, .flash_rd, .flash_addr, .opt,
    .flash_rdata);
  // ****************
  // Tasks
  // ****************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    k = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task wt(input bit s, input logic v);
    t = 0;
    while ((s ? cpu_run : flash_rd) !== v && t < 9000)
    begin
      @(posedge ref_clk);
      t++;
    end
  endtask
  task boot_check(input logic [7:0] o, input bit glitch);
    int lo;
    lo = o[2:1] != 0 ? 0 : 1 << (o[5] ? `OBL_WAIT_EXP1 : `OBL_WAIT_EXP0);
    @(posedge ref_clk);
    opt <= o;
    arst_n <= 0;
    reset_pin <= 0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    reset_pin <= 1;
    if (glitch)
    begin
      @(posedge ref_clk);
      reset_pin <= 0;
      repeat (10) @(posedge ref_clk);
      chk("held_in_reset", 0, {flash_rd, cpu_run});
      reset_pin <= 1;
    end
    wt(0, 1);
    wt(0, 0);
    wt(1, 1);
    chk("settle_time", 1, t >= lo && t <= lo + 10);
    @(posedge ref_clk);
    chk("sys_rst", 1, sys_rst_n);
  endtask
  task cfg_check(input logic [7:0] o);
    src = o[2] ? 2'b10 : o[2:1];
    av(0, `OBL_REG_CFG, 0);
    chk("status", {26'h0, 1'b1, o[3], src, 2'b11}, rd);
    chk("clk_src", src, sysclk_src);
    av(0, `OBL_REG_STAT, 0);
    chk("state", 3, rd);
    av(0, `OBL_REG_OPT, 0);
    chk("opt_byte", o, rd);
    chk("osc_pins", src == 0 ? 4'hc : src == 1 ? 4'h9 : 4'h3, {osc_in_pin_en,
      osc_out_pin_en, osc_in_port_en, osc_out_port_en});
    chk("pin_role", {o[3], !o[3]}, {reset_pin_keep, reset_alt_port_en});
  endtask
  task slow_check(input logic [7:0] o);
    av(1, `OBL_REG_SLOW, 1);
    repeat (3) @(posedge ref_clk);
    chk("halt_bit", {4{o[0]}}, {slow_osc_run, tmr_clk_en, wdt_clk_en,
      wdt_clk_force_slow});
    av(1, `OBL_REG_SLOW, 0);
    for (int k = 0; k < 3; k++)
    begin
      {halt_mode, stop_mode, wdt_sel_slow} <= k == 0 ? 3'h3 : k * 5 - 5;
      repeat (3) @(posedge ref_clk);
      chk("wdt_gate", {o[0], 1'b1}, {wdt_clk_en, tmr_clk_en});
    end
    {halt_mode, stop_mode, wdt_sel_slow} <= 3'h1;
  endtask
  task hold_check(input logic [7:0] o);
    av(1, `OBL_REG_OPT, {24'h0, ~o});
    av(0, `OBL_REG_OPT, 0);
    chk("opt_kept", o, rd);
    av(0, 4'h2, 0);
    chk("unmapped", 0, rd);
    reset_pin <= 0;
    repeat (6) @(posedge ref_clk);
    chk("pin_in_run", !o[3], cpu_run);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      boot_check(cases[i], i == 0);
      cfg_check(cases[i]);
      slow_check(cases[i]);
      hold_check(cases[i]);
      $display("option %h done", cases[i]);
    end
    tally_and_finish;
  end
  initial
  begin
    #800000;
    err_count++;
    tally_and_finish;
  end
endmodule
bind boot_option_byte_loader boot_option_byte_loader_assertions chk_u (
  .ref_clk, .arst_n, .reset_pin, .flash_rd, .halt_mode, .stop_mode,
  .wdt_sel_slow, .avs_read, .avs_write, .avs_waitrequest, .cpu_run,
  .reset_pin_keep, .reset_alt_port_en, .osc_in_pin_en, .osc_out_pin_en,
  .osc_in_port_en, .osc_out_port_en, .slow_osc_run, .wdt_clk_en,
  .wdt_clk_force_slow, .tmr_clk_en, .flash_addr, .sysclk_src);
